// ### rtl/fdsc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "fdsc_defs.vh"
module fdsc_top #(
  parameter [`FDSC_CNT_W-1:0] MISMATCH_CYCLES = `FDSC_MISMATCH_S * `FDSC_CLK_HZ,
  parameter [`FDSC_CNT_W-1:0] SAFETY_CYCLES = (`FDSC_SAFETY_MS * (`FDSC_CLK_HZ / `FDSC_MS_PER_S))
) (
  input wire CLK_SYS,
  input wire RESET_N,
  input wire [`FDSC_CODE_W-1:0] INT_A_CH1,
  input wire [`FDSC_CODE_W-1:0] INT_A_CH2,
  input wire [`FDSC_CODE_W-1:0] INT_B_CH1,
  input wire [`FDSC_CODE_W-1:0] INT_B_CH2,
  input wire [`FDSC_CODE_W-1:0] FLK_A_CH1,
  input wire [`FDSC_CODE_W-1:0] FLK_A_CH2,
  input wire [`FDSC_CODE_W-1:0] FLK_B_CH1,
  input wire [`FDSC_CODE_W-1:0] FLK_B_CH2,
  input wire RANGE_B_SEL,
  input wire RANGE_LINE_OK,
  input wire [`FDSC_MEAS_W-1:0] INTENSITY,
  input wire [`FDSC_MEAS_W-1:0] FLICKER_HZ,
  output reg FLAME_ON,
  output reg SWITCH_ERROR,
  output reg ERROR_SHUTDOWN,
  output reg PERIODIC_DET_EN,
  output reg RANGE_B_ACTIVE
);

  localparam SW = `FDSC_N_SEL * `FDSC_CODE_W;
  localparam PW = `FDSC_N_PIN;

  // Intensity threshold per code, linear steps of arbitrary units
  function [`FDSC_MEAS_W-1:0] int_thr;
    input [`FDSC_CODE_W-1:0] code;
    begin
      int_thr = {code, {`FDSC_INT_SHIFT{1'b0}}};
    end
  endfunction

  // Flicker threshold in Hz per code; code A maps to 150 Hz
  function [`FDSC_MEAS_W-1:0] flk_thr;
    input [`FDSC_CODE_W-1:0] code;
    begin
      case (code)
        4'h0: flk_thr = `FDSC_FLK_THR_0;
        4'h1: flk_thr = `FDSC_FLK_THR_1;
        4'h2: flk_thr = `FDSC_FLK_THR_2;
        4'h3: flk_thr = `FDSC_FLK_THR_3;
        4'h4: flk_thr = `FDSC_FLK_THR_4;
        4'h5: flk_thr = `FDSC_FLK_THR_5;
        4'h6: flk_thr = `FDSC_FLK_THR_6;
        4'h7: flk_thr = `FDSC_FLK_THR_7;
        4'h8: flk_thr = `FDSC_FLK_THR_8;
        4'h9: flk_thr = `FDSC_FLK_THR_9;
        4'hA: flk_thr = `FDSC_FLK_THR_A;
        4'hB: flk_thr = `FDSC_FLK_THR_B;
        4'hC: flk_thr = `FDSC_FLK_THR_C;
        4'hD: flk_thr = `FDSC_FLK_THR_D;
        4'hE: flk_thr = `FDSC_FLK_THR_E;
        default: flk_thr = `FDSC_FLK_THR_F;
      endcase
    end
  endfunction

  // Pick one selector copy out of the synchronised switch word
  function [`FDSC_CODE_W-1:0] sel_code;
    input [SW-1:0] word;
    input integer idx;
    begin
      sel_code = word[idx * `FDSC_CODE_W +: `FDSC_CODE_W];
    end
  endfunction

  // One channel's verdict, worked out from that channel's own copies only
  function chan_ok;
    input [`FDSC_MEAS_W-1:0] inten;
    input [`FDSC_MEAS_W-1:0] flk;
    input [`FDSC_CODE_W-1:0] icode;
    input [`FDSC_CODE_W-1:0] fcode;
    reg int_ok;
    reg flk_ok;
    begin
      int_ok = inten > int_thr(icode);
      flk_ok = (fcode == `FDSC_CODE_OFF) || (flk > flk_thr(fcode));
      chan_ok = int_ok & flk_ok;
    end
  endfunction

  // Switch and range pins are asynchronous levels
  wire [SW-1:0] sw_raw = {INT_A_CH1, INT_A_CH2, INT_B_CH1, INT_B_CH2,
                          FLK_A_CH1, FLK_A_CH2, FLK_B_CH1, FLK_B_CH2};
  wire [PW-1:0] pin_raw = {RANGE_B_SEL, RANGE_LINE_OK};

  reg [SW-1:0] sw_s1_r;
  reg [SW-1:0] sw_s2_r;
  reg [SW-1:0] sw_s3_r;
  reg [SW-1:0] sw_r;
  reg [PW-1:0] pin_s1_r;
  reg [PW-1:0] pin_s2_r;
  reg [PW-1:0] pin_s3_r;
  reg [PW-1:0] pin_r;
  integer i;
  integer j;

  // Three stages; a bit is taken only when stages 2 and 3 agree,
  // so a glitch lasting one cycle on any bit is never taken into sw_r
  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      sw_s1_r <= {SW{1'b0}};
      sw_s2_r <= {SW{1'b0}};
      sw_s3_r <= {SW{1'b0}};
      sw_r <= {SW{1'b0}};
    end else begin
      sw_s1_r <= sw_raw;
      sw_s2_r <= sw_s1_r;
      sw_s3_r <= sw_s2_r;
      for (i = 0; i < SW; i = i + 1) begin
        if (sw_s2_r[i] == sw_s3_r[i]) begin
          sw_r[i] <= sw_s2_r[i];
        end
      end
    end
  end

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_s1_r <= {PW{1'b0}};
      pin_s2_r <= {PW{1'b0}};
      pin_s3_r <= {PW{1'b0}};
      pin_r <= {PW{1'b0}};
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      for (j = 0; j < PW; j = j + 1) begin
        if (pin_s2_r[j] == pin_s3_r[j]) begin
          pin_r[j] <= pin_s2_r[j];
        end
      end
    end
  end

  // Timers and next-state values
  reg [`FDSC_CNT_W-1:0] mm_cnt_r;
  reg [`FDSC_CNT_W-1:0] mm_cnt_nxt;
  reg [`FDSC_CNT_W-1:0] safe_cnt_r;
  reg [`FDSC_CNT_W-1:0] safe_cnt_nxt;
  reg flame_nxt;
  reg shutdown_nxt;
  reg switch_err_nxt;
  reg range_nxt;
  reg periodic_nxt;

  // Synchronised copies, one per channel and range
  wire [`FDSC_CODE_W-1:0] ia1 = sel_code(sw_r, `FDSC_IDX_INT_A_CH1);
  wire [`FDSC_CODE_W-1:0] ia2 = sel_code(sw_r, `FDSC_IDX_INT_A_CH2);
  wire [`FDSC_CODE_W-1:0] ib1 = sel_code(sw_r, `FDSC_IDX_INT_B_CH1);
  wire [`FDSC_CODE_W-1:0] ib2 = sel_code(sw_r, `FDSC_IDX_INT_B_CH2);
  wire [`FDSC_CODE_W-1:0] fa1 = sel_code(sw_r, `FDSC_IDX_FLK_A_CH1);
  wire [`FDSC_CODE_W-1:0] fa2 = sel_code(sw_r, `FDSC_IDX_FLK_A_CH2);
  wire [`FDSC_CODE_W-1:0] fb1 = sel_code(sw_r, `FDSC_IDX_FLK_B_CH1);
  wire [`FDSC_CODE_W-1:0] fb2 = sel_code(sw_r, `FDSC_IDX_FLK_B_CH2);

  // A broken control line reads as not-ok and forces the first range
  wire range_b = pin_r[`FDSC_PIN_SEL] & pin_r[`FDSC_PIN_LINE_OK];

  // Each channel chooses its own copies for the active range
  wire [`FDSC_CODE_W-1:0] i_c1 = range_b ? ib1 : ia1;
  wire [`FDSC_CODE_W-1:0] i_c2 = range_b ? ib2 : ia2;
  wire [`FDSC_CODE_W-1:0] f_c1 = range_b ? fb1 : fa1;
  wire [`FDSC_CODE_W-1:0] f_c2 = range_b ? fb2 : fa2;

  // Periodic detection runs only where the channel has a flicker threshold
  wire per_en1 = (f_c1 != `FDSC_CODE_OFF);
  wire per_en2 = (f_c2 != `FDSC_CODE_OFF);

  // Both channels decide independently
  wire dec1 = chan_ok(INTENSITY, FLICKER_HZ, i_c1, f_c1);
  wire dec2 = chan_ok(INTENSITY, FLICKER_HZ, i_c2, f_c2);
  wire agree = (dec1 == dec2);
  wire both_on = dec1 & dec2;

  // Any copy pair differing, in either range, is a switch fault;
  // the idle range is watched too, so a bad switch shows before it is needed
  wire mm_int_a = (ia1 != ia2);
  wire mm_int_b = (ib1 != ib2);
  wire mm_flk_a = (fa1 != fa2);
  wire mm_flk_b = (fb1 != fb2);
  wire mismatch = mm_int_a | mm_int_b | mm_flk_a | mm_flk_b;

  // Copies that differ give the operator the grace time to equalise them,
  // so a channel disagreement caused by them only darkens the flame
  wire mm_expire = mismatch && (mm_cnt_r >= MISMATCH_CYCLES - 1'b1);
  wire safe_expire = (safe_cnt_r >= SAFETY_CYCLES - 1'b1);

  // Mismatch timer saturates at its limit, so a lasting fault cannot wrap
  always @* begin
    mm_cnt_nxt = mm_cnt_r;
    if (!mismatch) begin
      mm_cnt_nxt = {`FDSC_CNT_W{1'b0}};
    end else if (mm_cnt_r < MISMATCH_CYCLES) begin
      mm_cnt_nxt = mm_cnt_r + 1'b1;
    end
  end

  // Shutdown latches until reset; only an expired switch mismatch sets it
  always @* begin
    shutdown_nxt = ERROR_SHUTDOWN;
    if (mm_expire) begin
      shutdown_nxt = 1'b1;
    end
  end

  // Flame comes on at once but is dropped only after the safety time,
  // and never stands while in shutdown or while the channels disagree
  always @* begin
    flame_nxt = FLAME_ON;
    safe_cnt_nxt = safe_cnt_r;
    if (ERROR_SHUTDOWN || !agree) begin
      flame_nxt = 1'b0;
      safe_cnt_nxt = {`FDSC_CNT_W{1'b0}};
    end else if (both_on) begin
      flame_nxt = 1'b1;
      safe_cnt_nxt = {`FDSC_CNT_W{1'b0}};
    end else if (FLAME_ON) begin
      if (safe_expire) begin
        flame_nxt = 1'b0;
        safe_cnt_nxt = {`FDSC_CNT_W{1'b0}};
      end else begin
        safe_cnt_nxt = safe_cnt_r + 1'b1;
      end
    end
  end

  // Status outputs follow the synchronised state
  always @* begin
    switch_err_nxt = mismatch;
    range_nxt = range_b;
    periodic_nxt = per_en1 & per_en2;
  end

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      mm_cnt_r <= {`FDSC_CNT_W{1'b0}};
      safe_cnt_r <= {`FDSC_CNT_W{1'b0}};
    end else begin
      mm_cnt_r <= mm_cnt_nxt;
      safe_cnt_r <= safe_cnt_nxt;
    end
  end

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      FLAME_ON <= 1'b0;
    end else begin
      FLAME_ON <= flame_nxt;
    end
  end

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ERROR_SHUTDOWN <= 1'b0;
    end else begin
      ERROR_SHUTDOWN <= shutdown_nxt;
    end
  end

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      SWITCH_ERROR <= 1'b0;
    end else begin
      SWITCH_ERROR <= switch_err_nxt;
    end
  end

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      RANGE_B_ACTIVE <= `FDSC_RANGE_A;
    end else begin
      RANGE_B_ACTIVE <= range_nxt;
    end
  end

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PERIODIC_DET_EN <= 1'b0;
    end else begin
      PERIODIC_DET_EN <= periodic_nxt;
    end
  end

endmodule // fdsc_top
`default_nettype wire

// ### rtl/fdsc_defs.vh
`ifndef FDSC_DEFS_VH
`define FDSC_DEFS_VH
`define FDSC_CLK_HZ 40000000
`define FDSC_MISMATCH_S 8
`define FDSC_SAFETY_MS 1000
`define FDSC_CODE_W 4
`define FDSC_MEAS_W 16
`define FDSC_CNT_W 32
`define FDSC_CODE_DEFAULT 4'h0
`define FDSC_CODE_OFF 4'h0
`define FDSC_RANGE_A 1'b0
`define FDSC_MS_PER_S 1000
`define FDSC_N_SEL 8
`define FDSC_N_PIN 2
`define FDSC_INT_SHIFT 12
`define FDSC_IDX_INT_A_CH1 7
`define FDSC_IDX_INT_A_CH2 6
`define FDSC_IDX_INT_B_CH1 5
`define FDSC_IDX_INT_B_CH2 4
`define FDSC_IDX_FLK_A_CH1 3
`define FDSC_IDX_FLK_A_CH2 2
`define FDSC_IDX_FLK_B_CH1 1
`define FDSC_IDX_FLK_B_CH2 0
`define FDSC_PIN_SEL 1
`define FDSC_PIN_LINE_OK 0
`define FDSC_FLK_THR_0 16'h0000
`define FDSC_FLK_THR_1 16'h000A
`define FDSC_FLK_THR_2 16'h0014
`define FDSC_FLK_THR_3 16'h001E
`define FDSC_FLK_THR_4 16'h0028
`define FDSC_FLK_THR_5 16'h0032
`define FDSC_FLK_THR_6 16'h003C
`define FDSC_FLK_THR_7 16'h0050
`define FDSC_FLK_THR_8 16'h0064
`define FDSC_FLK_THR_9 16'h0078
`define FDSC_FLK_THR_A 16'h0096
`define FDSC_FLK_THR_B 16'h00B4
`define FDSC_FLK_THR_C 16'h00C8
`define FDSC_FLK_THR_D 16'h00FA
`define FDSC_FLK_THR_E 16'h012C
`define FDSC_FLK_THR_F 16'h0190
`endif

// ### verif/fdsc_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fdsc_chk #(parameter int MISMATCH_CYCLES = 50) (
  input wire logic CLK_SYS, RESET_N, FLAME_ON, SWITCH_ERROR, ERROR_SHUTDOWN,
  input wire logic PERIODIC_DET_EN, RANGE_B_ACTIVE, RANGE_LINE_OK,
  input wire logic [3:0] INT_B_CH1, INT_B_CH2, FLK_A_CH1, FLK_B_CH1);
  localparam int LO = MISMATCH_CYCLES - 8, HI = MISMATCH_CYCLES + 3;
  logic [31:0] n_r;
  // Age of the switch error, so the shutdown can be pinned near its limit
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N) n_r <= 32'h0000_0000;
    else n_r <= SWITCH_ERROR ? n_r + 32'h0000_0001 : 32'h0000_0000;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  sequence s_split; (INT_B_CH1 != INT_B_CH2) [*8]; endsequence
  property p_split; s_split |-> SWITCH_ERROR; endproperty
  a_split: assert property (p_split) else $error("no switch error");
  property p_early; $rose(ERROR_SHUTDOWN) |-> n_r >= LO; endproperty
  a_early: assert property (p_early) else $error("early shutdown");
  property p_late; n_r == HI |-> ERROR_SHUTDOWN; endproperty
  a_late: assert property (p_late) else $error("late shutdown");
  property p_hold; ERROR_SHUTDOWN |=> ERROR_SHUTDOWN; endproperty
  a_hold: assert property (p_hold) else $error("shutdown released");
  property p_dark; ERROR_SHUTDOWN |=> !FLAME_ON; endproperty
  a_dark: assert property (p_dark) else $error("flame in shutdown");
  property p_off; $fell(FLAME_ON) && !ERROR_SHUTDOWN |-> $past(FLAME_ON, 16); endproperty
  a_off: assert property (p_off) else $error("flame dropped early");
  property p_per; $stable({FLK_A_CH1, FLK_B_CH1, RANGE_B_ACTIVE}) [*8] |-> ERROR_SHUTDOWN ||
    PERIODIC_DET_EN == ((RANGE_B_ACTIVE ? FLK_B_CH1 : FLK_A_CH1) != 4'h0); endproperty
  a_per: assert property (p_per) else $error("periodic enable wrong");
  property p_rng; (!RANGE_LINE_OK) [*8] |-> !RANGE_B_ACTIVE; endproperty
  a_rng: assert property (p_rng) else $error("no range fallback");
endmodule // fdsc_chk
bind fdsc_top fdsc_chk #(.MISMATCH_CYCLES(MISMATCH_CYCLES)) u_fdsc_chk (.*);
`default_nettype wire

// ### verif/fdsc_burner.sv
`timescale 1ns/1ps
`default_nettype none
module fdsc_burner (input wire logic want_b, cut, output wire logic range_b_sel, line_ok);
  // A cut select wire is taken to float high, the worst case for the fallback
  assign range_b_sel = want_b | cut;
  assign line_ok = !cut;
endmodule // fdsc_burner
`default_nettype wire

// ### verif/fdsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fdsc_top_tb;
  logic CLK_SYS = 1'h0, RESET_N = 1'h0, want_b = 1'h0, cut = 1'h0;
  wire RANGE_B_SEL, RANGE_LINE_OK, FLAME_ON, SWITCH_ERROR, ERROR_SHUTDOWN, PERIODIC_DET_EN, RANGE_B_ACTIVE;
  wire [3:0] INT_A_CH1, INT_A_CH2, INT_B_CH1, INT_B_CH2, FLK_A_CH1, FLK_A_CH2, FLK_B_CH1, FLK_B_CH2;
  logic [15:0] INTENSITY = 16'h0000, FLICKER_HZ = 16'h0000;
  logic [31:0] cw = 32'h3355_AA00;
  int error_cnt = 0, n_checks = 0;
  wire [4:0] flags = {RANGE_B_ACTIVE, FLAME_ON, SWITCH_ERROR, ERROR_SHUTDOWN, PERIODIC_DET_EN};
  assign {INT_A_CH1, INT_A_CH2, INT_B_CH1, INT_B_CH2, FLK_A_CH1, FLK_A_CH2, FLK_B_CH1, FLK_B_CH2} = cw;
  fdsc_top #(.MISMATCH_CYCLES(50), .SAFETY_CYCLES(20)) u_fdsc_top (.*);
  fdsc_burner u_fdsc_burner (.want_b(want_b), .cut(cut), .range_b_sel(RANGE_B_SEL), .line_ok(RANGE_LINE_OK));
  initial forever #12.5 CLK_SYS = ~CLK_SYS;
  task chk(input logic [4:0] got, exp);
    n_checks++;
    error_cnt += int'(got !== exp);
    if (got !== exp) $display("Error at %0t: flags %b, expected %b", $time, got, exp);
  endtask
  task run(input logic [15:0] i, f, input logic [31:0] c, input logic b, x, input int n, input logic [4:0] e);
    @(posedge CLK_SYS);
    {INTENSITY, FLICKER_HZ, cw, want_b, cut} <= {i, f, c, b, x};
    repeat (n) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    chk(flags, e);
  endtask
  task results;
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The run needs about 240 cycles; a hang is cut off well past that
  initial begin
    repeat (2000) @(posedge CLK_SYS);
    error_cnt++;
    results;
  end
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RESET_N <= 1'h1;
    repeat (5) @(posedge CLK_SYS);
    run(16'h3000, 16'h0097, 32'h3355_AA00, 1'h0, 1'h0, 8, 5'h01);
    run(16'h3001, 16'h0097, 32'h3355_AA00, 1'h0, 1'h0, 8, 5'h09);
    run(16'h3001, 16'h0096, 32'h3355_AA00, 1'h0, 1'h0, 12, 5'h09);
    run(16'h3001, 16'h0096, 32'h3355_AA00, 1'h0, 1'h0, 14, 5'h01);
    run(16'h5001, 16'h0000, 32'h3355_AA00, 1'h1, 1'h0, 12, 5'h18);
    run(16'h3001, 16'h0097, 32'h3355_AA00, 1'h1, 1'h0, 30, 5'h10);
    run(16'h3001, 16'h0097, 32'h3355_AA00, 1'h1, 1'h1, 10, 5'h09);
    run(16'h3001, 16'h0097, 32'h3365_AA00, 1'h1, 1'h1, 40, 5'h0D);
    run(16'h3001, 16'h0097, 32'h3355_AA00, 1'h1, 1'h1, 10, 5'h09);
    run(16'h3001, 16'h0097, 32'h3365_AA00, 1'h1, 1'h1, 40, 5'h0D);
    repeat (30) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    chk(flags & 5'h0A, 5'h02);
    results;
  end
endmodule // fdsc_top_tb
`default_nettype wire
